/* pcf_top.sv */
/*
 * position command filter: input fifo, first-order smoothing, fir average,
 * damping width limiter and the rules for switching filter settings.
 * assumes command counts arrive as one signed word per 0.166 ms period and
 * that all inputs are synchronous to mclk_i.
 */
// Functional notes
// R1: four damping widths, 0..1000, default zero
// R2: width limited to min(freq, 2000-freq)
// R3: host keeps widths zero unless tuning
// R4: first-order lag on command, 0..10000 steps
// R5: lag constant equals setting times 0.1 ms
// R6: smoothing switches on count rise when positioned
// R7: smoothing change delayed; event during delay suspends
// R8: fir average on command, 0..10000 steps
// R9: average time equals setting times 0.1 ms
// R10: fir wait from setting, pad or 1.05
// R11: fir change waits for pulse-free wait time
// R12: fir change delayed; event during delay suspends
// R13: frequency 0..9 disables its damping stage
// R14: zero time setting passes command unchanged

// ****************
// fifo
// ****************
module pcf_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic rdy;
    } pcf_fifo_st_t;
    pcf_fifo_st_t st_ff, nxt_st;
    logic [W-1:0] mem [DEPTH];
    logic push, pop;

    assign push = in_valid_i && !st_ff.full;
    assign pop = out_ready_i && (st_ff.cnt != '0);
    assign in_ready_o = st_ff.rdy;
    assign out_valid_o = st_ff.cnt != '0;
    assign out_data_o = mem[st_ff.rp];

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        nxt_st.full = nxt_st.cnt == (AW+1)'(DEPTH);
        // ready is registered so the port comes straight from a flop
        nxt_st.rdy = !nxt_st.full;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
            st_ff.rdy <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
        if (push) begin
            mem[st_ff.wp] <= in_data_i;
        end
    end

    a_fifo_bound: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.cnt <= (AW+1)'(DEPTH) &&
        st_ff.full == (st_ff.cnt == (AW+1)'(DEPTH)) &&
        st_ff.rdy == !st_ff.full)
        else $error("fifo count out of range");
endmodule : pcf_fifo

// ****************
// filter top
// ****************
module pcf_top
    import pcf_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = pcf_pkg::TICK_CYC,
    parameter int unsigned FIR_MEM = pcf_pkg::FIR_DEPTH
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // command counts, one word per period
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic signed [15:0] cmd_delta_i,
    // settings and status
    input wire logic [13:0] cmd_smoothing_time_i,
    input wire logic [13:0] cmd_fir_average_time_i,
    input wire pcf_pkg::pcf_damp_t [3:0] damp_i,
    input wire logic pos_done_i,
    // filtered command
    output logic out_valid_o,
    output logic signed [15:0] out_delta_o,
    output logic [3:0][9:0] damp_filter_width_o,
    output logic [13:0] sm_active_o,
    output logic [13:0] fir_active_o
);
    import pcf_pkg::*;

    function automatic logic [13:0] lim_time(input logic [13:0] s);
        lim_time = (s > 14'(TIME_MAX)) ? 14'(TIME_MAX) : s;
    endfunction : lim_time

    // widths above the frequency distance become the distance
    function automatic logic [9:0] damp_clamp(input pcf_damp_t d);
        int unsigned w, f, lim;
        w = (d.width > 10'(DW_MAX)) ? DW_MAX : int'(d.width); // R1
        f = (d.freq > 11'(DF_SPAN)) ? DF_SPAN : int'(d.freq);
        lim = (f < DF_SPAN - f) ? f : DF_SPAN - f; // R2
        if (f <= DF_OFF_MAX) begin
            w = 0; // R13
        end else if (w > lim) begin
            w = lim;
        end
        damp_clamp = 10'(w);
    endfunction : damp_clamp

    function automatic logic [12:0] fir_len(input logic [13:0] s);
        int unsigned n;
        n = (int'(s) * STEP_US + TICK_US / 2) / TICK_US; // R9
        fir_len = (n == 0) ? 13'h0001 : 13'(n);
    endfunction : fir_len

    function automatic logic [15:0] fir_wait(input logic [13:0] s);
        int unsigned us;
        us = (s < 14'(FIR_LONG)) ? int'(s) * STEP_US + FIR_PAD_US
                                 : int'(s) * FIR_SCALE; // R10
        fir_wait = 16'((us + TICK_US - 1) / TICK_US);
    endfunction : fir_wait

    // read-out rounds: a lag creeping up from below never loses a pulse
    function automatic logic signed [31:0] q16_round(
        input logic signed [47:0] p
    );
        logic signed [47:0] r;
        r = p + 48'sh0000_0000_8000;
        q16_round = r[47:16];
    endfunction : q16_round

    pcf_state_t st_ff, nxt_st;
    logic signed [15:0] fir_mem [FIR_MEM];
    logic f_valid, f_ready, tick, nz, ev, fir_wr;
    logic signed [15:0] f_data, old_d;
    logic [16:0] sm_k, fir_g;
    logic [12:0] n_len;
    logic signed [65:0] sm_prod;
    logic signed [49:0] fir_prod;
    logic signed [31:0] sm_d, fir_d;

    pcf_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(cmd_valid_i),
        .in_ready_o(cmd_ready_o),
        .in_data_i(cmd_delta_i),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o(f_data)
    );

    // the fifo drains one word per period, so a fast source stalls on it
    assign tick = st_ff.tick_cnt == '0;
    assign f_ready = tick;
    assign nz = f_valid && (f_data != '0);
    assign ev = tick && nz && !st_ff.prev_nz && pos_done_i; // R6
    assign n_len = fir_len(st_ff.fir_act);
    assign old_d = (st_ff.fir_fill >= n_len)
                   ? fir_mem[st_ff.fir_wp - n_len] : 16'sh0000;
    assign fir_wr = tick && (st_ff.fir_act != '0);

    always_comb begin
        logic signed [47:0] x;
        x = '0;
        nxt_st = st_ff;
        sm_k = '0;
        fir_g = '0;
        sm_prod = '0;
        fir_prod = '0;
        sm_d = '0;
        fir_d = '0;
        nxt_st.out_valid = 1'b0;
        nxt_st.tick_cnt = tick ? 14'(TICK_CYCLES - 1) : st_ff.tick_cnt - 1'b1;
        for (int i = 0; i < 4; i++) begin
            nxt_st.dw_eff[i] = damp_clamp(damp_i[i]); // R2
        end
        if (tick) begin
            x = f_valid ? 48'(f_data) : 48'sh0;
            nxt_st.prev_nz = nz;
            nxt_st.idle_ticks = nz ? 16'h0000
                : (st_ff.idle_ticks == 16'hffff ? st_ff.idle_ticks
                                                : st_ff.idle_ticks + 1'b1);
            // smoothing stage, position domain in q16
            nxt_st.pin = st_ff.pin + (x <<< 16);
            if (st_ff.sm_act == '0) begin
                nxt_st.psm = nxt_st.pin; // R14
            end else begin
                sm_k = 17'((SM_K_NUM / int'(st_ff.sm_act) > Q_ONE)
                       ? Q_ONE : SM_K_NUM / int'(st_ff.sm_act)); // R5
                sm_prod = (nxt_st.pin - st_ff.psm) * $signed({1'b0, sm_k});
                nxt_st.psm = st_ff.psm + 48'(sm_prod >>> 16); // R4
            end
            sm_d = q16_round(nxt_st.psm) - st_ff.sm_prev;
            nxt_st.sm_prev = q16_round(nxt_st.psm);
            // fir stage, running sum over n periods
            if (st_ff.fir_act == '0) begin
                nxt_st.pfir = st_ff.pfir + {sm_d, 16'h0000}; // R14
            end else begin
                fir_g = 17'(Q_ONE / int'(n_len));
                nxt_st.fir_sum = st_ff.fir_sum + 32'(signed'(sm_d[15:0]))
                                 - 32'(old_d); // R8
                nxt_st.fir_wp = st_ff.fir_wp + 1'b1;
                if (st_ff.fir_fill < n_len) begin
                    nxt_st.fir_fill = st_ff.fir_fill + 1'b1;
                end
                fir_prod = nxt_st.fir_sum * $signed({1'b0, fir_g});
                nxt_st.pfir = st_ff.pfir + 48'(fir_prod); // R9
            end
            fir_d = q16_round(nxt_st.pfir) - st_ff.fir_prev;
            nxt_st.fir_prev = q16_round(nxt_st.pfir);
            nxt_st.out_valid = 1'b1;
            nxt_st.out_delta = fir_d[15:0];
            // smoothing switch only at the rising count while positioned
            if (st_ff.sm_pending && ev) begin
                if (st_ff.sm_dly == '0) begin
                    nxt_st.sm_act = st_ff.sm_pend; // R6
                    nxt_st.sm_pending = 1'b0;
                end else begin
                    nxt_st.sm_dly = 3'(SM_DLY_TICKS); // R7
                end
            end else if (st_ff.sm_pending && st_ff.sm_dly != '0) begin
                nxt_st.sm_dly = st_ff.sm_dly - 1'b1;
            end
            // fir switch after a pulse-free wait; pulses in delay suspend it
            if (st_ff.fir_pending && nz) begin
                nxt_st.fir_dly = 3'(FIR_DLY_TICKS); // R12
            end else if (st_ff.fir_pending && st_ff.fir_dly != '0) begin
                nxt_st.fir_dly = st_ff.fir_dly - 1'b1;
            end else if (st_ff.fir_pending && st_ff.idle_ticks >=
                    fir_wait((st_ff.fir_act > st_ff.fir_pend)
                    ? st_ff.fir_act : st_ff.fir_pend)) begin
                nxt_st.fir_act = st_ff.fir_pend; // R11
                nxt_st.fir_pending = 1'b0;
                nxt_st.fir_sum = '0;
                nxt_st.fir_fill = '0;
            end
        end
        // a new setting restarts the application delay; after the tick
        // logic so an apply in the same cycle cannot swallow it
        if (lim_time(cmd_smoothing_time_i) != (st_ff.sm_pending
                ? st_ff.sm_pend : st_ff.sm_act)) begin
            nxt_st.sm_pend = lim_time(cmd_smoothing_time_i); // R7
            nxt_st.sm_pending = 1'b1;
            nxt_st.sm_dly = 3'(SM_DLY_TICKS);
        end
        if (lim_time(cmd_fir_average_time_i) != (st_ff.fir_pending
                ? st_ff.fir_pend : st_ff.fir_act)) begin
            nxt_st.fir_pend = lim_time(cmd_fir_average_time_i); // R12
            nxt_st.fir_pending = 1'b1;
            nxt_st.fir_dly = 3'(FIR_DLY_TICKS);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
            st_ff.tick_cnt <= 14'(TICK_CYCLES - 1);
            st_ff.sm_act <= TIME_RST;
            st_ff.fir_act <= TIME_RST;
            st_ff.dw_eff <= {4{DW_RST}};
        end else begin
            st_ff <= nxt_st;
        end
        if (fir_wr) begin
            fir_mem[st_ff.fir_wp] <= sm_d[15:0];
        end
    end

    assign out_valid_o = st_ff.out_valid;
    assign out_delta_o = st_ff.out_delta;
    assign damp_filter_width_o = st_ff.dw_eff;
    assign sm_active_o = st_ff.sm_act;
    assign fir_active_o = st_ff.fir_act;

    // ****************
    // checks
    // ****************
    a_out_on_tick: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.out_valid |-> $past(tick))
        else $error("output word outside a period edge");
    a_width_limit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> st_ff.dw_eff[0] <= 10'(DW_MAX)) // R1
        else $error("damping width above maximum");
    a_width_span: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ($past(rst_n_i) && damp_i[0] == $past(damp_i[0])) |->
        (11'(st_ff.dw_eff[0]) <= damp_i[0].freq &&
         11'(st_ff.dw_eff[0]) <= 11'(DF_SPAN) - damp_i[0].freq)) // R2
        else $error("damping width beyond frequency distance");
    a_damp_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (damp_i[1].freq <= 11'(DF_OFF_MAX)) |=> (st_ff.dw_eff[1] == '0)) // R13
        else $error("disabled damping stage kept a width");
    a_sm_only_ev: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (st_ff.sm_act != $past(st_ff.sm_act)) |-> $past(ev)) // R6
        else $error("smoothing switched without a count rise");
    a_sm_delay: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ev && st_ff.sm_pending && st_ff.sm_dly != '0) |=>
        (st_ff.sm_pending && st_ff.sm_dly == 3'(SM_DLY_TICKS))) // R7
        else $error("smoothing change not suspended");
    a_fir_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (st_ff.fir_act != $past(st_ff.fir_act)) |->
        ($past(st_ff.idle_ticks) != '0 && !$past(nz))) // R11
        else $error("fir switched while pulses present");
    a_fir_suspend: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (tick && nz && st_ff.fir_pending) |=>
        (st_ff.fir_pending && st_ff.fir_dly == 3'(FIR_DLY_TICKS))) // R12
        else $error("fir change not suspended");
    a_pass_thru: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (tick && st_ff.sm_act == '0 && st_ff.fir_act == '0 && f_valid &&
         st_ff.psm == st_ff.pin && st_ff.pfir[47:16] == st_ff.fir_prev &&
         st_ff.pfir[15:0] == '0 && st_ff.psm[15:0] == '0 &&
         st_ff.sm_prev == st_ff.psm[47:16])
        |=> (out_delta_o == $past(f_data))) // R14
        else $error("zero settings did not pass the command");
endmodule : pcf_top

/* pcf_pkg.sv */
/*
 * shared constants and types of the position command filter.
 * assumes a single 50 MHz clock and settings that are plain levels.
 */
package pcf_pkg;
    // ****************
    // timing
    // ****************
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned TICK_NS = 166000;
    localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TICK_US = 166;
    localparam int unsigned SM_DLY_TICKS = 4;
    localparam int unsigned FIR_DLY_TICKS = 4;
    // ****************
    // setting limits, units of 0.1 Hz / 0.1 ms
    // ****************
    localparam int unsigned DW_MAX = 1000;
    localparam int unsigned DF_SPAN = 2000;
    localparam int unsigned DF_OFF_MAX = 9;
    localparam int unsigned TIME_MAX = 10000;
    localparam int unsigned FIR_LONG = 100;
    localparam int unsigned FIR_PAD_US = 250;
    localparam int unsigned FIR_SCALE = 105;
    localparam int unsigned STEP_US = 100;
    localparam int unsigned SM_K_NUM = 108790;
    localparam int unsigned Q_ONE = 65536;
    localparam int unsigned FIR_DEPTH = 8192;
    localparam int unsigned FIFO_DEPTH = 16;
    // ****************
    // reset values
    // ****************
    localparam logic [13:0] TIME_RST = 14'h0000;
    localparam logic [9:0] DW_RST = 10'h000;
    // ****************
    // carriers
    // ****************
    typedef struct packed {
        logic [10:0] freq;
        logic [9:0] width;
    } pcf_damp_t;
    typedef struct packed {
        logic [13:0] tick_cnt;
        logic out_valid;
        logic signed [15:0] out_delta;
        logic [13:0] sm_act;
        logic [13:0] sm_pend;
        logic sm_pending;
        logic [2:0] sm_dly;
        logic [13:0] fir_act;
        logic [13:0] fir_pend;
        logic fir_pending;
        logic [2:0] fir_dly;
        logic [15:0] idle_ticks;
        logic prev_nz;
        logic signed [47:0] pin;
        logic signed [47:0] psm;
        logic signed [31:0] sm_prev;
        logic signed [31:0] fir_sum;
        logic [12:0] fir_wp;
        logic [12:0] fir_fill;
        logic signed [47:0] pfir;
        logic signed [31:0] fir_prev;
        logic [3:0][9:0] dw_eff;
    } pcf_state_t;
endpackage : pcf_pkg

/* pcf_host.sv */
/*
 * host model: queues command words and offers them on valid/ready.
 * assumes the bench pushes words away from the rising clock edge.
 */
// ****************
// host controller
// ****************
module pcf_host (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // command words toward the filter
    input wire logic cmd_ready_i,
    output logic cmd_valid_o,
    output logic signed [15:0] cmd_delta_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic signed [15:0] q [$];
    logic signed [15:0] last;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_delta_o = 16'h0000;
        last = 16'h0000;
    end
    task automatic push(input logic signed [15:0] d);
        q.push_back(d);
    endtask : push
    // a word is held unchanged until the edge where ready is seen high
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            q.delete();
            cmd_valid_o <= 1'b0;
        end else begin
            if (cmd_valid_o && cmd_ready_i) void'(q.pop_front());
            if (q.size() != 0) begin
                cmd_valid_o <= 1'b1;
                cmd_delta_o <= q[0];
                last <= q[0];
            end else begin
                // idle line shows the inverse, never a stale word
                cmd_valid_o <= 1'b0;
                cmd_delta_o <= ~last;
            end
        end
    end
endmodule : pcf_host

/* position_command_filter_test.sv */
/*
 * self-checking bench of pcf_top fed by the host model.
 * assumes a period shortened to 20 clocks.
 */
// ****************
// bench
// ****************
module position_command_filter_test
    import pcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned TC = 20;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cv;
    logic cr;
    logic signed [15:0] cd;
    logic [13:0] sm_t = 14'h0000;
    logic [13:0] fir_t = 14'h0000;
    pcf_damp_t [3:0] damp = '0;
    logic pos_done = 1'b0;
    logic ov;
    logic signed [15:0] od;
    logic [3:0][9:0] dw;
    logic [13:0] sm_a;
    logic [13:0] fir_a;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int total = 0;
    int t0;
    int n;
    logic signed [15:0] o;
    logic signed [15:0] first;
    typedef struct packed {
        logic [10:0] f;
        logic [9:0] w;
        logic [9:0] e;
    } pcf_row_t;
    pcf_row_t rows [9] = '{
        '{11'h005, 10'h1f4, 10'h000}, '{11'h009, 10'h1f4, 10'h000},
        '{11'h00a, 10'h1f4, 10'h00a}, '{11'h3e8, 10'h3e8, 10'h3e8},
        '{11'h5dc, 10'h3e8, 10'h1f4}, '{11'h7d0, 10'h320, 10'h000},
        '{11'h12c, 10'h0c8, 10'h0c8}, '{11'h7cf, 10'h3e8, 10'h001},
        '{11'h3e8, 10'h3ff, 10'h3e8}
    };
    always #10 mclk = ~mclk;
    pcf_host i_pcf_host (
        .mclk_i(mclk), .rst_n_i(rst_n), .cmd_ready_i(cr),
        .cmd_valid_o(cv), .cmd_delta_o(cd)
    );
    pcf_top #(.TICK_CYCLES(TC)) i_pcf_top (
        .mclk_i(mclk), .rst_n_i(rst_n), .cmd_valid_i(cv),
        .cmd_ready_o(cr), .cmd_delta_i(cd),
        .cmd_smoothing_time_i(sm_t), .cmd_fir_average_time_i(fir_t),
        .damp_i(damp), .pos_done_i(pos_done), .out_valid_o(ov),
        .out_delta_o(od), .damp_filter_width_o(dw),
        .sm_active_o(sm_a), .fir_active_o(fir_a)
    );
    always @(negedge mclk) begin
        if (ov === 1'b1) total += od;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            results();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic reset_chk;
        check(16'(ov), 16'h0000);
        check(16'(sm_a), 16'h0000);
        check(16'(fir_a), 16'h0000);
        for (int k = 0; k < 4; k++) check(16'(dw[k]), 16'h0000);
    endtask : reset_chk
    task automatic tick_out(output logic signed [15:0] d);
        int c;
        c = 0;
        do begin
            @(negedge mclk);
            c++;
        end while (ov !== 1'b1 && c < 100);
        if (ov !== 1'b1) n_fail++;
        d = od;
    endtask : tick_out
    // aligning first keeps each pushed word ahead of its period edge
    task automatic run(input int cnt, input logic signed [15:0] d);
        logic signed [15:0] r;
        tick_out(r);
        for (int i = 0; i < cnt; i++) begin
            i_pcf_host.push(d);
            tick_out(r);
            if (i == 0) first = r;
        end
    endtask : run
    initial begin
        repeat (2) @(negedge mclk);
        reset_chk();
        @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge mclk);
            for (int k = 0; k < 4; k++) damp[k] <= '{rows[i].f, rows[i].w};
            repeat (2) @(negedge mclk);
            for (int k = 0; k < 4; k++) begin
                check(16'(dw[k]), 16'(rows[i].e));
            end
        end
        @(posedge mclk);
        damp <= '0;
        tick_out(o);
        for (int i = 0; i < 20; i++) i_pcf_host.push(16'(i * 7 - 30));
        n = 0;
        while (cr === 1'b1 && n < 60) begin
            @(negedge mclk);
            n++;
        end
        check(16'(cr), 16'h0000);
        for (int i = 0; i < 20; i++) begin
            tick_out(o);
            check(16'(o), 16'(i * 7 - 30));
        end
        tick_out(o);
        check(16'(o), 16'h0000);
        @(posedge mclk);
        fir_t <= 14'h000a;
        repeat (2) @(negedge mclk);
        check(16'(fir_a), 16'h0000);
        run(20, 16'h0000);
        check(16'(fir_a), 16'h000a);
        t0 = total;
        run(1, 16'h003c);
        check(16'(first >= 9 && first <= 11), 16'h0001);
        run(11, 16'h003c);
        run(12, 16'h0000);
        check(16'(total - t0), 16'h02d0);
        @(posedge mclk);
        fir_t <= 14'h0014;
        run(25, 16'h003c);
        check(16'(fir_a), 16'h000a);
        run(10, 16'h0000);
        check(16'(fir_a), 16'h000a);
        run(12, 16'h0000);
        check(16'(fir_a), 16'h0014);
        @(posedge mclk);
        fir_t <= 14'h0000;
        run(22, 16'h0000);
        check(16'(fir_a), 16'h0000);
        @(posedge mclk);
        sm_t <= 14'h0032;
        run(6, 16'h0000);
        run(2, 16'h0005);
        check(16'(sm_a), 16'h0000);
        @(posedge mclk);
        pos_done <= 1'b1;
        run(6, 16'h0000);
        run(1, 16'h0005);
        check(16'(sm_a), 16'h0032);
        run(40, 16'h0000);
        run(1, 16'h03e8);
        check(16'(first >= 30 && first <= 36), 16'h0001);
        @(posedge mclk);
        sm_t <= 14'h0064;
        run(1, 16'h0005);
        check(16'(sm_a), 16'h0032);
        run(6, 16'h0000);
        run(1, 16'h0005);
        check(16'(sm_a), 16'h0064);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(negedge mclk);
        reset_chk();
        results();
    end
endmodule : position_command_filter_test
